//--- logic/frlm_pkg.sv
// Constants, encodings and register map for the float register load/move unit
//----------------------------------------------------------------------------
// Behaviour
// - Forward-copy move: first word E223, second word 00000 plus 3-bit destination.
// - Forward-copy move loads the register and writes that word at operand plus two.
// - Forward-copy updates only four flags from bit 31, exponent and all-zero tests.
// - Forward-copy and upper-half load each finish in one cycle, no delay slots.
// - Upper-half load: first word prefix 1110100000000, 3 immediate bits, then 13 more.
// - Upper-half load puts immediate in bits 31:16 and clears bits 15:0.
// - Immediate loads, upper or lower half, leave every status flag unchanged.
// - Lower-half load: first word prefix 1110100000001, second word as upper-half load.
// - Lower-half load writes bits 15:0 and keeps bits 31:16.
// - Three-bit destination index selects one of eight float registers.
//----------------------------------------------------------------------------
package frlm_pkg;
   // Opcode encodings
   localparam logic [15:0] FWD_COPY_OPCODE = 16'hE223;
   localparam logic [12:0] UPPER_PREFIX = 13'h1D00;
   localparam logic [12:0] LOWER_PREFIX = 13'h1D01;
   localparam logic [4:0] FWD_SECOND_ZERO = 5'h00;
   localparam logic [31:0] FWD_COPY_STEP = 32'h00000002;
   // Float word fields
   localparam int SIGN_BIT = 31;
   localparam int EXP_HI = 30;
   localparam int EXP_LO = 23;
   // Status word bit positions
   localparam int FLAG_FNEG = 0;
   localparam int FLAG_FZERO = 1;
   localparam int FLAG_INEG = 2;
   localparam int FLAG_IZERO = 3;
   localparam int FLAG_W = 4;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   // Register map, byte addresses
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [2:0] FREG_BLOCK = 3'h1;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic CTRL_ENABLE_RESET = 1'b1;
   localparam int NUM_FREGS = 8;
endpackage

//--- logic/frlm_flag_eval.sv
// Flag evaluation for a word moved from memory into a float register
`timescale 1ns/1ps
module frlm_flag_eval
   import frlm_pkg::*;
(
   input wire logic [31:0] value_i,
   output logic [3:0] flags_o
);
   logic exp_zero;

   assign exp_zero = (value_i[EXP_HI:EXP_LO] == 8'h00);

   always_comb
   begin
      flags_o = 4'h0;
      flags_o[FLAG_FNEG] = value_i[SIGN_BIT] & ~exp_zero;
      flags_o[FLAG_FZERO] = exp_zero;
      flags_o[FLAG_INEG] = value_i[SIGN_BIT];
      flags_o[FLAG_IZERO] = (value_i == 32'h00000000);
   end
endmodule

//--- logic/frlm_unit.sv
// Decode and execute of float register memory-copy and immediate loads
`timescale 1ns/1ps
module frlm_unit
   import frlm_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Instruction issue from host pipeline
   input wire logic instr_valid_i,
   input wire logic [15:0] instr_first_i,
   input wire logic [15:0] instr_second_i,
   input wire logic [31:0] mem_addr_i,
   input wire logic [31:0] mem_rdata_i,
   output logic instr_done_o,
   output logic instr_illegal_o,
   output logic mem_wr_o,
   output logic [31:0] mem_waddr_o,
   output logic [31:0] mem_wdata_o,
   output logic [3:0] flags_o,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o
);
   typedef struct packed {
      logic [NUM_FREGS-1:0][31:0] freg;
      logic [3:0] flags;
      logic enable;
      logic ack;
      logic [31:0] rdata;
      logic mem_wr;
      logic [31:0] mem_waddr;
      logic [31:0] mem_wdata;
      logic done;
      logic illegal;
   } frlm_state_type;

   frlm_state_type state;
   frlm_state_type next_state;

   logic is_fwd;
   logic is_upper;
   logic is_lower;
   logic [2:0] fwd_dest;
   logic [2:0] imm_dest;
   logic [15:0] imm_value;
   logic [3:0] fwd_flags;
   logic bus_req;
   logic bus_wr;

   //-------------------------------------------------------------------------
   // Instruction decode
   //-------------------------------------------------------------------------
   assign is_fwd = (instr_first_i == FWD_COPY_OPCODE)
                   && (instr_second_i[15:11] == FWD_SECOND_ZERO);
   assign is_upper = (instr_first_i[15:3] == UPPER_PREFIX);
   assign is_lower = (instr_first_i[15:3] == LOWER_PREFIX);
   assign fwd_dest = instr_second_i[10:8];
   assign imm_dest = instr_second_i[2:0];
   assign imm_value = {instr_first_i[2:0], instr_second_i[15:3]};

   frlm_flag_eval u_flag_eval
   (
      .value_i(mem_rdata_i),
      .flags_o(fwd_flags)
   );

   assign bus_req = cyc_i & stb_i & ~state.ack;
   assign bus_wr = bus_req & we_i & sel_i[0];

   //-------------------------------------------------------------------------
   // Next state
   //-------------------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      next_state.ack = bus_req;
      next_state.mem_wr = 1'b0;
      next_state.done = 1'b0;
      next_state.illegal = 1'b0;
      // Register reads, unmapped addresses read zero
      next_state.rdata = 32'h00000000;
      if (adr_i == CTRL_OFFSET)
      begin
         next_state.rdata[CTRL_ENABLE_BIT] = state.enable;
      end
      else if (adr_i == STATUS_OFFSET)
      begin
         next_state.rdata[FLAG_W-1:0] = state.flags;
      end
      else if (adr_i[7:5] == FREG_BLOCK && adr_i[1:0] == 2'h0)
      begin
         next_state.rdata = state.freg[adr_i[4:2]];
      end
      // Register writes, float registers are read-only on the bus
      if (bus_wr && adr_i == CTRL_OFFSET)
      begin
         next_state.enable = dat_i[CTRL_ENABLE_BIT];
      end
      if (bus_wr && adr_i == STATUS_OFFSET)
      begin
         next_state.flags = dat_i[FLAG_W-1:0];
      end
      // Instruction execution, wins over a same-cycle bus write
      if (instr_valid_i && state.enable)
      begin
         next_state.done = is_fwd | is_upper | is_lower;
         next_state.illegal = ~(is_fwd | is_upper | is_lower);
         if (is_fwd)
         begin
            next_state.freg[fwd_dest] = mem_rdata_i;
            next_state.mem_wr = 1'b1;
            next_state.mem_waddr = mem_addr_i + FWD_COPY_STEP;
            next_state.mem_wdata = mem_rdata_i;
            next_state.flags = fwd_flags;
         end
         else if (is_upper)
         begin
            next_state.freg[imm_dest] = {imm_value, 16'h0000};
         end
         else if (is_lower)
         begin
            next_state.freg[imm_dest][15:0] = imm_value;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= '0;
         state.enable <= CTRL_ENABLE_RESET;
         state.flags <= FLAGS_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign instr_done_o = state.done;
   assign instr_illegal_o = state.illegal;
   assign mem_wr_o = state.mem_wr;
   assign mem_waddr_o = state.mem_waddr;
   assign mem_wdata_o = state.mem_wdata;
   assign flags_o = state.flags;
   assign dat_o = state.rdata;
   assign ack_o = state.ack;

   //-------------------------------------------------------------------------
   // Assertions
   //-------------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic go;
   assign go = instr_valid_i & state.enable;

   sequence s_upper;
      go && is_upper;
   endsequence

   sequence s_lower_same;
      go && is_lower && imm_dest == $past(imm_dest);
   endsequence

   property p_fwd_decode;
      mem_wr_o |-> $past(instr_valid_i) && $past(instr_first_i) == FWD_COPY_OPCODE
         && $past(instr_second_i[15:11]) == FWD_SECOND_ZERO;
   endproperty
   a_fwd_decode: assert property (p_fwd_decode) else $error("copy write without opcode");

   property p_fwd_copy;
      go && is_fwd |=> mem_wr_o && mem_waddr_o == $past(mem_addr_i) + FWD_COPY_STEP
         && mem_wdata_o == state.freg[$past(fwd_dest)];
   endproperty
   a_fwd_copy: assert property (p_fwd_copy) else $error("forward copy wrong");

   property p_fwd_reg;
      go && is_fwd |=> state.freg[$past(fwd_dest)] == $past(mem_rdata_i);
   endproperty
   a_fwd_reg: assert property (p_fwd_reg) else $error("copy register load wrong");

   property p_fwd_flags;
      go && is_fwd |=> flags_o[FLAG_INEG] == $past(mem_rdata_i[31])
         && flags_o[FLAG_IZERO] == ($past(mem_rdata_i) == 32'h0)
         && flags_o[FLAG_FZERO] == ($past(mem_rdata_i[30:23]) == 8'h00)
         && flags_o[FLAG_FNEG] == ($past(mem_rdata_i[31])
         && $past(mem_rdata_i[30:23]) != 8'h00);
   endproperty
   a_fwd_flags: assert property (p_fwd_flags) else $error("copy flags wrong");

   property p_one_cycle;
      go && (is_fwd || is_upper || is_lower) |=> instr_done_o
         ##1 (!instr_done_o || $past(go));
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("load not done in one cycle");

   property p_upper;
      go && is_upper |=> state.freg[$past(imm_dest)] == {$past(imm_value), 16'h0000};
   endproperty
   a_upper: assert property (p_upper) else $error("upper load wrong");

   property p_imm_flags;
      go && (is_upper || is_lower) |=> $stable(flags_o);
   endproperty
   a_imm_flags: assert property (p_imm_flags) else $error("immediate changed flags");

   property p_lower;
      go && is_lower |=> state.freg[$past(imm_dest)][15:0] == $past(imm_value)
         && state.freg[$past(imm_dest)][31:16] == $past(state.freg[imm_dest][31:16]);
   endproperty
   a_lower: assert property (p_lower) else $error("lower load wrong");

   property p_pair;
      s_upper ##1 s_lower_same |=> state.freg[$past(imm_dest)]
         == {$past(imm_value, 2), $past(imm_value)};
   endproperty
   a_pair: assert property (p_pair) else $error("constant pair wrong");

   property p_copy_match;
      mem_wr_o |-> $past(mem_rdata_i) == mem_wdata_o;
   endproperty
   a_copy_match: assert property (p_copy_match) else $error("copy differs from read");

   property p_decode_upper;
      go && instr_first_i[15:3] == 13'h1D00 |=> instr_done_o && !instr_illegal_o
         && !mem_wr_o;
   endproperty
   a_decode_upper: assert property (p_decode_upper) else $error("upper decode wrong");
endmodule

//--- verification/frlm_mem_model.sv
// Data memory model behind the forward-copy move
`timescale 1ns/1ps
module frlm_mem_model
(
   input wire logic clk_i,
   input wire logic valid_i,
   input wire logic [31:0] addr_i,
   input wire logic wr_i,
   input wire logic [31:0] waddr_i,
   input wire logic [31:0] wdata_i,
   output logic [31:0] rdata_o
);
   logic [31:0] mem [0:15];
   // Inverted data outside an operand read
   assign rdata_o = valid_i ? mem[addr_i[3:0]] : ~mem[addr_i[3:0]];
   always @(posedge clk_i)
   begin
      if (wr_i)
      begin
         mem[waddr_i[3:0]] <= wdata_i;
      end
   end
endmodule

//--- verification/frlm_unit_test.sv
// Self-checking bench for the float register load/move unit
`timescale 1ns/1ps
module frlm_unit_test
   import frlm_pkg::*;
;
   logic clk_i, rst_i, instr_valid_i, cyc_i, stb_i, we_i;
   logic instr_done_o, instr_illegal_o, mem_wr_o, ack_o;
   logic [15:0] instr_first_i, instr_second_i, lf;
   logic [31:0] mem_addr_i, mem_rdata_i, mem_waddr_o, mem_wdata_o, dat_i, dat_o, rd, v, a;
   logic [7:0] adr_i;
   logic [3:0] sel_i, flags_o, fl;
   logic [31:0] fr [0:7];
   logic [31:0] sp [0:3] = '{32'h0, 32'h80000000, 32'h807FFFFF, 32'h00800000};
   int bad_count, total_checks;
   frlm_unit frlm_unit_i (.clk_i, .rst_i, .instr_valid_i, .instr_first_i, .instr_second_i,
      .mem_addr_i, .mem_rdata_i, .instr_done_o, .instr_illegal_o, .mem_wr_o, .mem_waddr_o,
      .mem_wdata_o, .flags_o, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o);
   frlm_mem_model frlm_mem_model_i (.clk_i, .valid_i(instr_valid_i), .addr_i(mem_addr_i),
      .wr_i(mem_wr_o), .waddr_i(mem_waddr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
   //------------------------------
   // Helpers
   //------------------------------
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, ad, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge clk_i);
      end
      rd = dat_o;
      {cyc_i, stb_i} <= 2'b00;
      if (n == 20)
      begin
         bad_count++;
         print_verdict;
      end
   endtask
   task automatic ins(input logic [15:0] f, input logic [15:0] s, input logic [31:0] ad);
      @(posedge clk_i);
      {instr_valid_i, instr_first_i, instr_second_i, mem_addr_i} <= {1'b1, f, s, ad};
   endtask
   task automatic fin;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
   endtask
   task automatic rdregs;
      for (int i = 0; i < 8; i++)
      begin
         wb(1'b0, 8'(8'h20 + 4 * i), 32'h0);
         chk(rd, fr[i]);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial
   begin
      #100000;
      bad_count++;
      print_verdict;
   end
   initial
   begin
      {rst_i, instr_valid_i, cyc_i, stb_i, we_i, adr_i, dat_i} = {1'b1, 44'h0};
      {instr_first_i, instr_second_i, mem_addr_i, sel_i, lf} = {64'h0, 4'hF, 16'h0056};
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, CTRL_OFFSET, 32'h0);
      chk(rd, 32'h1);
      wb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
      $display("bus test done");
      for (int i = 0; i < 12; i++)
      begin
         lf = nxt(lf);
         v[31:16] = lf;
         lf = nxt(lf);
         v = (i < 8) ? {v[31:16], lf} : sp[i - 8];
         a = {28'h0, lf[3:0]};
         frlm_mem_model_i.mem[a[3:0]] = v;
         ins(FWD_COPY_OPCODE, {5'h00, 3'(i), lf[11:4]}, a);
         fin;
         fr[i % 8] = v;
         fl = {v == 0, v[31], v[30:23] == 0, v[31] && v[30:23] != 0};
         chk(instr_done_o, 1);
         chk(mem_wr_o, 1);
         chk(mem_waddr_o, a + 2);
         chk(mem_wdata_o, v);
         chk(flags_o, fl);
         @(posedge clk_i);
         #1;
         chk(frlm_mem_model_i.mem[4'(a[3:0] + 4'h2)], v);
      end
      rdregs;
      ins(FWD_COPY_OPCODE, 16'h0800, 32'h0);
      fin;
      chk(instr_illegal_o, 1);
      chk(mem_wr_o, 0);
      $display("copy test done");
      wb(1'b1, STATUS_OFFSET, 32'h5);
      fl = 4'h5;
      wb(1'b1, 8'h20, 32'hFFFFFFFF);
      wb(1'b0, 8'h20, 32'h0);
      chk(rd, fr[0]);
      for (int i = 0; i < 8; i++)
      begin
         lf = nxt(lf);
         v[31:16] = lf;
         lf = nxt(lf);
         v[15:0] = (i == 0) ? 16'h0 : lf;
         ins({UPPER_PREFIX, v[31:29]}, {v[28:16], 3'(i)}, 32'h0);
         if (v[15:0] != 0)
            ins({LOWER_PREFIX, v[15:13]}, {v[12:0], 3'(i)}, 32'h0);
         fin;
         fr[i] = v;
         chk(instr_done_o, 1);
         chk(flags_o, fl);
      end
      rdregs;
      $display("immediate test done");
      wb(1'b1, CTRL_OFFSET, 32'h0);
      ins({UPPER_PREFIX, 3'h7}, 16'hFFF9, 32'h0);
      fin;
      chk(instr_done_o, 0);
      wb(1'b1, CTRL_OFFSET, 32'h1);
      rdregs;
      $display("enable test done");
      @(posedge clk_i);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk(flags_o, 32'h0);
      for (int i = 0; i < 8; i++)
         fr[i] = 32'h0;
      rdregs;
      wb(1'b0, CTRL_OFFSET, 32'h0);
      chk(rd, 32'h1);
      $display("reset test done");
      print_verdict;
   end
endmodule
